// ---- core/blce_pkg.sv ----
// Constants, types and field layouts for the bit, literal and control core
// Contract
// - Bit ops use direct and indirect addressing
// - Clear bit: selected bit to zero, flags kept
// - Set bit: selected bit to one, flags kept
// - Opcode 0110: skip next when bit zero
// - Opcode 0111: skip next when bit one
// - Opcode in top bits, then 8/9-bit constant
// - Load literal into working register, flags kept
// - AND, OR, XOR literal into working register
// - XOR literal zero result sets Zero
// - Jump loads 9-bit target into counter
// - Call pushes next address, then jumps
// - Call and counter writes clear ninth bit
// - Return stack entries are nine bits wide
// - Every return pops stack into counter
// - Opcode 1000 returns, loads constant, flags kept
// - Interrupt return pops, keeps W, re-enables
// - Only interrupt return ends interrupt blocking
// - Status bits: 0 Carry, 1 Digit, 2 Zero
// - Jump is opcode 101 plus 9-bit target
package blce_pkg;
  // Datapath widths
  localparam int WORD_W = 12;
  localparam int PC_W = 9;
  localparam int DATA_W = 8;
  localparam int FILE_N = 32;
  localparam int STK_DEPTH = 2;
  // Opcodes, upper nibble of the word
  localparam logic [3:0] OP_CLR_BIT = 4'h4;
  localparam logic [3:0] OP_SET_BIT = 4'h5;
  localparam logic [3:0] OP_SKIP_CLR = 4'h6;
  localparam logic [3:0] OP_SKIP_SET = 4'h7;
  localparam logic [3:0] OP_RET_LIT = 4'h8;
  localparam logic [3:0] OP_CALL = 4'h9;
  localparam logic [3:0] OP_LOAD_LIT = 4'hC;
  localparam logic [3:0] OP_OR_LIT = 4'hD;
  localparam logic [3:0] OP_AND_LIT = 4'hE;
  localparam logic [3:0] OP_XOR_LIT = 4'hF;
  localparam logic [2:0] OP3_JUMP = 3'h5;
  localparam logic [11:0] WORD_INT_RET = 12'h002;
  // Special file addresses
  localparam logic [4:0] FA_INDIRECT = 5'h00;
  localparam logic [4:0] FA_PC = 5'h02;
  localparam logic [4:0] FA_STATUS = 5'h03;
  localparam logic [4:0] FA_SELECT = 5'h04;
  // Status flag positions
  localparam int ST_CARRY = 0;
  localparam int ST_DCARRY = 1;
  localparam int ST_ZERO = 2;
  // Interrupt entry address, arbitrary
  localparam logic [8:0] INT_VECTOR = 9'h004;
  // Register bus byte offsets and fields
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATE = 4'h4;
  localparam int CTRL_RUN = 0;
  localparam int STATE_ISR = 9;
  localparam int STATE_SKIP = 10;
  localparam int STATE_W_LSB = 16;
  localparam int STATE_ST_LSB = 24;
  // Sequencer states, one-hot
  typedef enum logic [2:0] {
    S_IDLE = 3'h1,
    S_RUN = 3'h2,
    S_SKIP = 3'h4
  } blce_state_t;
  // Fields of one instruction word
  typedef struct packed {
    logic [3:0] op;
    logic [2:0] bitn;
    logic [4:0] faddr;
  } blce_word_t;
endpackage : blce_pkg

// ---- core/blce_core.sv ----
// Decode and execute core for bit, literal and control instructions
//
// Implementation choices: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/100ps
module blce_core
  import blce_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [PC_W-1:0] imem_addr,
  input wire logic [WORD_W-1:0] imem_data,
  input wire logic imem_valid,
  input wire logic int_req_pin,
  output logic int_busy
);

  blce_state_t state_r; // Sequencer state
  blce_word_t iw; // Fields of the current word
  logic [PC_W-1:0] pc_r; // Program counter
  logic [PC_W-1:0] pc_nxt;
  logic [PC_W-1:0] stk_r [STK_DEPTH]; // Return stack, top at 0
  logic [DATA_W-1:0] w_r; // Working register
  logic [DATA_W-1:0] w_nxt;
  logic [DATA_W-1:0] status_r; // Status register
  logic [DATA_W-1:0] status_nxt;
  logic [DATA_W-1:0] rf_r [FILE_N]; // General file registers
  logic run_r; // Software run enable
  logic ack_r; // Bus answer cycle
  logic isr_r; // Interrupt service in progress
  logic int_s1_r, int_s2_r; // Request synchroniser
  logic exec; // Current word is executed
  logic take_int; // Interrupt entry instead of execution
  logic skip_hit; // Bit test asks for a skip
  logic push, pop; // Stack moves
  logic [4:0] ea; // Resolved file address
  logic [DATA_W-1:0] rd; // File read value
  logic [DATA_W-1:0] bitv; // Bit-modified value
  logic bit_wr; // Bit op writes the file
  logic [DATA_W-1:0] lit; // 8-bit literal field

  assign iw = imem_data;
  assign lit = imem_data[7:0];
  assign imem_addr = pc_r;
  assign int_busy = isr_r;

  // Only the running state takes a word, and an interrupt pre-empts it
  assign take_int = (state_r == S_RUN) && run_r && imem_valid &&
                    int_s2_r && !isr_r;
  assign exec = (state_r == S_RUN) && run_r && imem_valid && !take_int;

  // Indirect slot reads the select register for the real address
  always_comb begin
    ea = (iw.faddr == FA_INDIRECT) ? rf_r[FA_SELECT][4:0] : iw.faddr;
    unique case (ea)
      FA_INDIRECT: rd = '0; // Indirect onto itself reads zero
      FA_PC: rd = pc_r[7:0];
      FA_STATUS: rd = status_r;
      default: rd = rf_r[ea];
    endcase
  end

  // Bit modify and bit test on the resolved register
  always_comb begin
    bitv = rd;
    bit_wr = 1'b0;
    skip_hit = 1'b0;
    if (exec) begin
      unique case (iw.op)
        OP_CLR_BIT: begin
          bitv[iw.bitn] = 1'b0;
          bit_wr = (ea != FA_INDIRECT);
        end
        OP_SET_BIT: begin
          bitv[iw.bitn] = 1'b1;
          bit_wr = (ea != FA_INDIRECT);
        end
        OP_SKIP_CLR: skip_hit = !rd[iw.bitn];
        OP_SKIP_SET: skip_hit = rd[iw.bitn];
        default: skip_hit = 1'b0;
      endcase
    end
  end

  // Literal ops on W; Zero follows the logic ops only
  always_comb begin
    w_nxt = w_r;
    status_nxt = status_r;
    if (bit_wr && ea == FA_STATUS)
      status_nxt = bitv;
    if (exec) begin
      unique case (iw.op)
        OP_LOAD_LIT: w_nxt = lit;
        OP_RET_LIT: w_nxt = lit;
        OP_AND_LIT: w_nxt = w_r & lit;
        OP_OR_LIT: w_nxt = w_r | lit;
        OP_XOR_LIT: w_nxt = w_r ^ lit;
        default: w_nxt = w_r;
      endcase
      if (iw.op == OP_AND_LIT || iw.op == OP_OR_LIT ||
          iw.op == OP_XOR_LIT)
        status_nxt[ST_ZERO] = (w_nxt == '0);
    end
  end

  // Next program counter and stack moves
  always_comb begin
    push = take_int;
    pop = 1'b0;
    pc_nxt = pc_r;
    if (take_int) begin
      pc_nxt = INT_VECTOR;
    end else if (exec) begin
      pc_nxt = pc_r + 9'h001;
      if (iw.op[3:1] == OP3_JUMP) begin
        pc_nxt = imem_data[8:0];
      end else if (iw.op == OP_CALL) begin
        push = 1'b1;
        pc_nxt = {1'b0, lit};
      end else if (iw.op == OP_RET_LIT || imem_data == WORD_INT_RET) begin
        pop = 1'b1;
        pc_nxt = stk_r[0];
      end else if (bit_wr && ea == FA_PC) begin
        pc_nxt = {1'b0, bitv};
      end
    end else if (state_r == S_SKIP && run_r && imem_valid) begin
      pc_nxt = pc_r + 9'h001;
    end
  end

  // Program counter
  always_ff @(posedge mclk) begin
    if (reset)
      pc_r <= '0;
    else
      pc_r <= pc_nxt;
  end

  // Return stack, full nine-bit entries
  always_ff @(posedge mclk) begin
    if (reset) begin
      for (int i = 0; i < STK_DEPTH; i++)
        stk_r[i] <= '0;
    end else if (push) begin
      // Interrupt entry saves the pre-empted word's address
      stk_r[0] <= take_int ? pc_r : pc_r + 9'h001;
      for (int i = 1; i < STK_DEPTH; i++)
        stk_r[i] <= stk_r[i-1];
    end else if (pop) begin
      // Bottom entry is kept, deeper returns repeat it
      for (int i = 0; i < STK_DEPTH - 1; i++)
        stk_r[i] <= stk_r[i+1];
    end
  end

  // Working and status registers
  always_ff @(posedge mclk) begin
    if (reset) begin
      w_r <= '0;
      status_r <= '0;
    end else begin
      w_r <= w_nxt;
      status_r <= status_nxt;
    end
  end

  // General file, written only by bit ops here
  always_ff @(posedge mclk) begin
    if (reset) begin
      for (int i = 0; i < FILE_N; i++)
        rf_r[i] <= '0;
    end else if (bit_wr && ea != FA_PC && ea != FA_STATUS) begin
      rf_r[ea] <= bitv;
    end
  end

  // Sequencer: a met skip discards exactly one word
  always_ff @(posedge mclk) begin
    if (reset)
      state_r <= S_IDLE;
    else begin
      unique case (state_r)
        S_IDLE: if (run_r) state_r <= S_RUN;
        S_RUN: begin
          if (!run_r)
            state_r <= S_IDLE;
          else if (skip_hit)
            state_r <= S_SKIP;
        end
        S_SKIP: if (run_r && imem_valid) state_r <= S_RUN;
        default: state_r <= S_IDLE; // Recover from a bad code
      endcase
    end
  end

  // Interrupt request pin, two stages before use
  always_ff @(posedge mclk) begin
    if (reset) begin
      int_s1_r <= 1'b0;
      int_s2_r <= 1'b0;
    end else begin
      int_s1_r <= int_req_pin;
      int_s2_r <= int_s1_r;
    end
  end

  // Service blocking; literal return must not lift it
  always_ff @(posedge mclk) begin
    if (reset)
      isr_r <= 1'b0;
    else if (take_int)
      isr_r <= 1'b1;
    else if (exec && imem_data == WORD_INT_RET)
      isr_r <= 1'b0;
  end

  // Bus: one wait cycle, answer on the second edge
  assign avs_waitrequest = (avs_read || avs_write) && !ack_r;

  // Answer flag, one cycle high per request
  always_ff @(posedge mclk) begin
    if (reset)
      ack_r <= 1'b0;
    else
      ack_r <= (avs_read || avs_write) && !ack_r;
  end

  // Control register write, taken at the answering edge
  always_ff @(posedge mclk) begin
    if (reset)
      run_r <= 1'b0;
    else if (avs_write && ack_r && avs_address == REG_CTRL)
      run_r <= avs_writedata[CTRL_RUN];
  end

  // Read data, captured one edge ahead of the answer
  always_ff @(posedge mclk) begin
    if (reset)
      avs_readdata <= '0;
    else if (avs_read && !ack_r) begin
      avs_readdata <= '0; // Unmapped reads as zero
      if (avs_address == REG_CTRL)
        avs_readdata[CTRL_RUN] <= run_r;
      else if (avs_address == REG_STATE) begin
        avs_readdata[PC_W-1:0] <= pc_r;
        avs_readdata[STATE_ISR] <= isr_r;
        avs_readdata[STATE_SKIP] <= (state_r == S_SKIP);
        avs_readdata[STATE_W_LSB +: DATA_W] <= w_r;
        avs_readdata[STATE_ST_LSB +: DATA_W] <= status_r;
      end
    end
  end

  // Checks on the executed instruction groups
  a_jump_target: assert property (@(posedge mclk) disable iff (reset)
    exec && imem_data[11:9] == OP3_JUMP |=>
    pc_r == $past(imem_data[8:0]))
    else $error("jump target not loaded");

  a_call_push: assert property (@(posedge mclk) disable iff (reset)
    exec && iw.op == OP_CALL |=>
    stk_r[0] == $past(pc_r) + 9'h001 && pc_r[8] == 1'b0 &&
    pc_r[7:0] == $past(imem_data[7:0]))
    else $error("call push or target wrong");

  a_ret_literal: assert property (@(posedge mclk) disable iff (reset)
    exec && iw.op == OP_RET_LIT |=>
    w_r == $past(imem_data[7:0]) && pc_r == $past(stk_r[0]) &&
    $stable(status_r))
    else $error("literal return wrong");

  a_int_return: assert property (@(posedge mclk) disable iff (reset)
    exec && imem_data == WORD_INT_RET |=>
    $stable(w_r) && !isr_r && pc_r == $past(stk_r[0]))
    else $error("interrupt return wrong");

  a_isr_blocked: assert property (@(posedge mclk) disable iff (reset)
    isr_r && !(exec && imem_data == WORD_INT_RET) |=> isr_r)
    else $error("service blocking lifted early");

  a_load_literal: assert property (@(posedge mclk) disable iff (reset)
    exec && iw.op == OP_LOAD_LIT |=>
    w_r == $past(imem_data[7:0]) && $stable(status_r))
    else $error("load literal wrong");

  a_xor_zero: assert property (@(posedge mclk) disable iff (reset)
    exec && iw.op == OP_XOR_LIT && w_r == lit |=>
    status_r[ST_ZERO] && w_r == '0)
    else $error("xor zero flag not set");

  a_and_zero: assert property (@(posedge mclk) disable iff (reset)
    exec && (iw.op == OP_AND_LIT || iw.op == OP_OR_LIT) |=>
    status_r[ST_ZERO] == (w_r == '0))
    else $error("and or zero flag wrong");

  a_skip_clear: assert property (@(posedge mclk) disable iff (reset)
    exec && iw.op == OP_SKIP_CLR && !rd[iw.bitn] && run_r |=>
    state_r == S_SKIP && $stable(status_r))
    else $error("skip on clear missed");

  a_skip_discard: assert property (@(posedge mclk) disable iff (reset)
    state_r == S_SKIP && run_r && imem_valid |=>
    pc_r == $past(pc_r) + 9'h001 && $stable(w_r) &&
    $stable(status_r) && state_r == S_RUN)
    else $error("skipped word had an effect");

  a_set_bit: assert property (@(posedge mclk) disable iff (reset)
    exec && iw.op == OP_SET_BIT && ea != FA_INDIRECT &&
    ea != FA_PC && ea != FA_STATUS |=>
    rf_r[$past(ea)] == ($past(rd) | (8'h01 << $past(iw.bitn))))
    else $error("set bit wrong");

endmodule : blce_core

// ---- test/blce_prog_mem.sv ----
// Program memory model that feeds instruction words to the core
`timescale 1ns/100ps
module blce_prog_mem
  import blce_pkg::*;
(
  input wire logic mclk,
  input wire logic slow,
  input wire logic [PC_W-1:0] imem_addr,
  output logic [WORD_W-1:0] imem_data,
  output logic imem_valid
);
  logic [WORD_W-1:0] mem [2**PC_W]; // Word store, filled by the bench
  logic tog_r = 1'h0; // Alternates to halve the word rate
  // Empty memory reads as no-op words
  initial begin
    foreach (mem[i]) mem[i] = 12'h000;
  end
  // Slow mode offers a word only every other cycle
  always @(posedge mclk) begin
    tog_r <= !tog_r;
  end
  assign imem_valid = !slow || tog_r;
  // A word not on offer shows its inverse, so a stale copy never passes
  assign imem_data = imem_valid ? mem[imem_addr] : ~mem[imem_addr];
endmodule : blce_prog_mem

// ---- test/blce_core_tb.sv ----
// Self-checking bench for the bit, literal and control core
`timescale 1ns/100ps
module blce_core_tb;
  import blce_pkg::*;
  logic mclk = 1'h0;
  logic reset = 1'h1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'h0;
  logic avs_write = 1'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [PC_W-1:0] imem_addr;
  logic [WORD_W-1:0] imem_data;
  logic imem_valid;
  logic int_req_pin = 1'h0;
  logic int_busy;
  logic slow = 1'h0; // Stalling program memory
  int mismatches = 0;
  int num_checks = 0;
  int cycles = 0; // Hang guard
  logic [31:0] rd; // Last read data
  blce_core blce_core_i(.mclk(mclk), .reset(reset),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .imem_addr(imem_addr), .imem_data(imem_data),
    .imem_valid(imem_valid), .int_req_pin(int_req_pin),
    .int_busy(int_busy));
  blce_prog_mem blce_prog_mem_i(.mclk(mclk), .slow(slow),
    .imem_addr(imem_addr), .imem_data(imem_data),
    .imem_valid(imem_valid));
  // 100 MHz clock
  always #5 mclk = !mclk;
  // Cut a hang short well past the expected run length
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      test_done();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One bus access, held until waitrequest is sampled low
  task automatic av(input logic wr, input logic [3:0] a,
                    input logic [31:0] d);
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge mclk);
    while (avs_waitrequest !== 1'h0) @(posedge mclk);
    rd = avs_readdata;
    avs_write <= 1'h0;
    avs_read <= 1'h0;
  endtask : av
  task automatic do_reset();
    reset <= 1'h1;
    repeat (10) @(posedge mclk);
    reset <= 1'h0;
  endtask : do_reset
  // Unlisted words become no-ops
  task automatic load(input int base, input logic [11:0] w [12]);
    for (int i = 0; i < 12; i++) blce_prog_mem_i.mem[base + i] = w[i];
  endtask : load
  task automatic till_pc(input logic [8:0] a);
    for (int n = 0; n < 300 && imem_addr !== a; n++) @(posedge mclk);
  endtask : till_pc
  // Run to a self-jump, stop, then compare the state word
  task automatic run(input logic [8:0] halt, input logic [31:0] exp);
    av(1'h1, REG_CTRL, 32'h1);
    av(1'h0, REG_CTRL, 32'h0);
    chk(rd, 32'h1);
    till_pc(halt);
    av(1'h1, REG_CTRL, 32'h0);
    av(1'h0, REG_STATE, 32'h0);
    chk(rd, exp);
    $display("Test halting at %h done", halt);
    do_reset();
  endtask : run
  task automatic test_done();
    $display("Checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : test_done
  initial begin
    do_reset();
    av(1'h0, REG_STATE, 32'h0);
    chk(rd, 32'h0); // Reset state
    av(1'h0, 4'h8, 32'h0);
    chk(rd, 32'h0); // Unmapped read
    $display("Test reset state done");
    // Literal group, Zero set by a matching exclusive OR
    load(0, '{0: 12'hC49, 1: 12'hE0F, 2: 12'hF09, 3: 12'hC77,
      4: 12'hA04, default: 12'h000});
    run(9'h004, 32'h0477_0004);
    // Flag bits driven by bit ops, Zero from OR and AND
    load(0, '{0: 12'hC80, 1: 12'hD01, 2: 12'h503, 3: 12'h523,
      4: 12'h403, 5: 12'hE00, 6: 12'hA06, default: 12'h000});
    run(9'h006, 32'h0600_0006);
    // Indirect bit ops and both skips, with a stalling memory
    slow <= 1'h1;
    load(0, '{12'h504, 12'h524, 12'h544, 12'h5A0, 12'h7A7, 12'hF01,
      12'h4A0, 12'h6A7, 12'hF02, 12'h7A7, 12'hF04, 12'hA0B});
    run(9'h00B, 32'h0004_000B);
    slow <= 1'h0;
    // Nested calls from above 255, both return kinds, then a bit write
    // to the counter file that must drop the ninth counter bit
    load(0, '{0: 12'hB50, default: 12'h000});
    load(9'h020, '{0: 12'h940, 1: 12'h8AB, default: 12'h000});
    load(9'h030, '{0: 12'h002, default: 12'h000});
    load(9'h040, '{0: 12'h8CD, default: 12'h000});
    load(9'h0D2, '{0: 12'hAD2, default: 12'h000});
    load(9'h150, '{0: 12'h920, 1: 12'h930, 2: 12'h5E2,
      default: 12'h000});
    run(9'h0D2, 32'h00AB_00D2);
    // Interrupt: subroutine return keeps service, interrupt return ends it
    load(0, '{0: 12'hA00, 4: 12'h910, 5: 12'h002, default: 12'h000});
    load(9'h010, '{0: 12'h8EE, default: 12'h000});
    av(1'h1, REG_CTRL, 32'h1);
    int_req_pin <= 1'h1;
    till_pc(9'h005);
    chk({31'h0, int_busy}, 32'h1);
    for (int n = 0; n < 50 && int_busy !== 1'h0; n++) @(posedge mclk);
    chk({23'h0, imem_addr}, 32'h0);
    for (int n = 0; n < 50 && int_busy !== 1'h1; n++) @(posedge mclk);
    chk({23'h0, imem_addr}, 32'h4);
    int_req_pin <= 1'h0;
    av(1'h0, REG_STATE, 32'h0);
    chk(rd[23:16], 32'hEE);
    $display("Test interrupt done");
    test_done();
  end
endmodule : blce_core_tb
